// *** src/shu_pkg.sv ***
// package: register map, field positions, vectors and shared types
package shu_pkg;
	// ************************************************************
	// register map (x data space)
	// ************************************************************
	localparam logic [15:0] ADDR_CLOCK_CONTROL = 16'hfff0;
	localparam logic [15:0] ADDR_CONTROL_STATUS = 16'hfff1;
	localparam logic [15:0] ADDR_OWN_ADDRESS = 16'hfff2;
	localparam logic [15:0] ADDR_DATA = 16'hfff3;
	localparam int DATA_W = 24;
	localparam int FIFO_DEPTH = 10;
	localparam int PTR_W = 4;
	localparam logic [PTR_W-1:0] FIFO_LAST = 4'h9;
	localparam logic [PTR_W:0] FIFO_FULL_COUNT = 5'h0a;
	// ************************************************************
	// writable masks and reset values
	// ************************************************************
	localparam logic [23:0] CLOCK_CONTROL_MASK = 24'h0031ff;
	localparam logic [23:0] CLOCK_CONTROL_RESET = 24'h000001;
	localparam logic [23:0] CONTROL_WRITE_MASK = 24'h007fff;
	localparam logic [23:0] CONTROL_RESET = 24'h000000;
	localparam logic [23:0] OWN_ADDRESS_MASK = 24'hf40000;
	localparam logic [23:0] OWN_ADDRESS_RESET = 24'hb00000;
	// ************************************************************
	// control/status bit positions
	// ************************************************************
	localparam int BIT_ENABLE = 0;
	localparam int BIT_BUS_ERR_IE = 10;
	localparam int BIT_TX_IE = 11;
	localparam int BIT_RX_IE0 = 12;
	localparam int BIT_RX_IE1 = 13;
	localparam int BIT_TX_UNDERRUN = 14;
	localparam int BIT_TX_EMPTY = 15;
	localparam int BIT_RX_NOT_EMPTY = 17;
	localparam int BIT_RX_FULL = 19;
	localparam int BIT_RX_OVERRUN = 20;
	localparam int BIT_BUS_ERR = 21;
	// ************************************************************
	// interrupt vectors in program space
	// ************************************************************
	localparam logic [15:0] VEC_TX_DATA = 16'h0020;
	localparam logic [15:0] VEC_TX_UNDERRUN = 16'h0022;
	localparam logic [15:0] VEC_RX_NOT_EMPTY = 16'h0024;
	localparam logic [15:0] VEC_RESERVED = 16'h0026;
	localparam logic [15:0] VEC_RX_FULL = 16'h0028;
	localparam logic [15:0] VEC_RX_OVERRUN = 16'h002a;
	localparam logic [15:0] VEC_BUS_ERR = 16'h002c;

	// processor x-space access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [DATA_W-1:0] wdata;
	} shu_bus_s;

	// events from the shift logic
	typedef struct packed {
		logic rx_push;
		logic [DATA_W-1:0] rx_word;
		logic tx_taken;
		logic tx_underrun;
		logic bus_error;
	} shu_link_s;
endpackage : shu_pkg

// *** src/shu_rx_fifo.sv ***
// ten-word receive fifo read through the data address
module shu_rx_fifo (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// fill side
	input wire logic push_in,
	input wire logic [shu_pkg::DATA_W-1:0] push_data_in,
	// drain side
	input wire logic pop_in,
	input wire logic flush_in,
	output logic [shu_pkg::DATA_W-1:0] head_out,
	output logic not_empty_out,
	output logic full_out,
	output logic overrun_out
);
	typedef struct packed {
		logic [shu_pkg::PTR_W-1:0] wp;
		logic [shu_pkg::PTR_W-1:0] rp;
		logic [shu_pkg::PTR_W:0] cnt;
	} shu_fifo_s;

	logic [shu_pkg::DATA_W-1:0] mem_q [shu_pkg::FIFO_DEPTH];
	shu_fifo_s st_q, st_d;
	logic do_push, do_pop;

	assign do_pop = pop_in && (st_q.cnt != '0);
	assign do_push = push_in && (st_q.cnt != shu_pkg::FIFO_FULL_COUNT || do_pop);
	assign overrun_out = push_in && !do_push;

	function automatic logic [shu_pkg::PTR_W-1:0] nxt(
		input logic [shu_pkg::PTR_W-1:0] p);
		nxt = (p == shu_pkg::FIFO_LAST) ? '0 : p + 4'h1;
	endfunction : nxt

	always_comb begin
		st_d = st_q;
		if (do_push)
			st_d.wp = nxt(st_q.wp);
		if (do_pop)
			st_d.rp = nxt(st_q.rp);
		st_d.cnt = st_q.cnt + {4'h0, do_push} - {4'h0, do_pop};
		if (flush_in)
			st_d = '0;
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// one storage word per entry, written only when addressed
	for (genvar i = 0; i < shu_pkg::FIFO_DEPTH; i++) begin : g_word
		always_ff @(posedge core_clk_in or negedge reset_n_in) begin
			if (!reset_n_in)
				mem_q[i] <= '0;
			else if (do_push && !flush_in && st_q.wp == i[shu_pkg::PTR_W-1:0])
				mem_q[i] <= push_data_in;
		end
	end

	assign head_out = (st_q.cnt == '0) ? '0 : mem_q[st_q.rp];
	assign not_empty_out = st_q.cnt != '0;
	assign full_out = st_q.cnt == shu_pkg::FIFO_FULL_COUNT;
endmodule : shu_rx_fifo

// *** src/shu_regmap.sv ***
// serial host unit register map and interrupt vectoring
// Operation
// - transmit-data interrupt uses vector 0x0020, first of slots to 0x002C
// - underrun vectors 0x0022, overrun 0x002A, bus error 0x002C
// - fifo not empty vectors 0x0024, full 0x0028; 0x0026 never used
// - priority bus error, overrun, underrun, full, transmit, not empty
// - clock control 0xFFF0, control/status 0xFFF1, own address 0xFFF2
// - 0xFFF3 reads receive fifo head and writes transmit holding
// - receive fifo holds ten 24-bit words behind one read address
// - reserved bits read zero; software should write zero
// - transmit write clears empty flag; interrupt requested while flag set
module shu_regmap (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// processor x-space port
	input wire shu_pkg::shu_bus_s bus_in,
	output logic [shu_pkg::DATA_W-1:0] rdata_out,
	// shift logic side
	input wire shu_pkg::shu_link_s link_in,
	output logic [shu_pkg::DATA_W-1:0] tx_word_out,
	output logic tx_word_valid_out,
	output logic [shu_pkg::DATA_W-1:0] clock_control_out,
	output logic [shu_pkg::DATA_W-1:0] own_address_out,
	output logic unit_enable_out,
	// interrupt controller
	output logic irq_out,
	output logic [15:0] irq_vector_out
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [23:0] clk_ctl;
		logic [23:0] ctl;
		logic [23:0] own_addr;
		logic [23:0] tx_hold;
		logic tx_empty;
		logic underrun;
		logic overrun;
		logic bus_err;
		logic [23:0] rdata;
	} shu_reg_s;

	shu_reg_s st_q, st_d;
	logic [23:0] fifo_head;
	logic fifo_ne, fifo_full, fifo_ovr;
	logic rd_data, wr_data, wr_ctl, flush;
	logic [23:0] status_view;
	logic req_bus, req_ovr, req_und, req_full, req_tx, req_ne;

	// ************************************************************
	// decode
	// ************************************************************
	assign rd_data = bus_in.rd && bus_in.addr == shu_pkg::ADDR_DATA;
	assign wr_data = bus_in.wr && bus_in.addr == shu_pkg::ADDR_DATA;
	assign wr_ctl = bus_in.wr && bus_in.addr == shu_pkg::ADDR_CONTROL_STATUS;
	assign flush = !st_q.ctl[shu_pkg::BIT_ENABLE];

	shu_rx_fifo u_fifo (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.push_in(link_in.rx_push),
		.push_data_in(link_in.rx_word),
		.pop_in(rd_data),
		.flush_in(flush),
		.head_out(fifo_head),
		.not_empty_out(fifo_ne),
		.full_out(fifo_full),
		.overrun_out(fifo_ovr)
	);

	// status bits merged over control bits; others read zero
	always_comb begin
		status_view = st_q.ctl & shu_pkg::CONTROL_WRITE_MASK;
		status_view[shu_pkg::BIT_TX_UNDERRUN] = st_q.underrun;
		status_view[shu_pkg::BIT_TX_EMPTY] = st_q.tx_empty;
		status_view[shu_pkg::BIT_RX_NOT_EMPTY] = fifo_ne;
		status_view[shu_pkg::BIT_RX_FULL] = fifo_full;
		status_view[shu_pkg::BIT_RX_OVERRUN] = st_q.overrun;
		status_view[shu_pkg::BIT_BUS_ERR] = st_q.bus_err;
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_d = st_q;
		st_d.rdata = '0;
		if (bus_in.rd) begin
			case (bus_in.addr)
				shu_pkg::ADDR_CLOCK_CONTROL: st_d.rdata = st_q.clk_ctl;
				shu_pkg::ADDR_CONTROL_STATUS: st_d.rdata = status_view;
				shu_pkg::ADDR_OWN_ADDRESS: st_d.rdata = st_q.own_addr;
				shu_pkg::ADDR_DATA: st_d.rdata = fifo_head;
				default: st_d.rdata = '0;
			endcase
		end
		if (bus_in.wr) begin
			case (bus_in.addr)
				shu_pkg::ADDR_CLOCK_CONTROL:
					st_d.clk_ctl = bus_in.wdata & shu_pkg::CLOCK_CONTROL_MASK;
				shu_pkg::ADDR_CONTROL_STATUS:
					st_d.ctl = bus_in.wdata & shu_pkg::CONTROL_WRITE_MASK;
				shu_pkg::ADDR_OWN_ADDRESS:
					st_d.own_addr = bus_in.wdata & shu_pkg::OWN_ADDRESS_MASK;
				shu_pkg::ADDR_DATA: begin
					st_d.tx_hold = bus_in.wdata;
					st_d.tx_empty = 1'b0;
				end
				default: st_d.ctl = st_q.ctl;
			endcase
		end
		// hardware events win over software clears
		if (wr_ctl) begin
			st_d.underrun = 1'b0;
			st_d.overrun = 1'b0;
			st_d.bus_err = 1'b0;
		end
		if (link_in.tx_taken)
			st_d.tx_empty = 1'b1;
		if (link_in.tx_underrun)
			st_d.underrun = 1'b1;
		if (fifo_ovr)
			st_d.overrun = 1'b1;
		if (link_in.bus_error)
			st_d.bus_err = 1'b1;
		if (flush) begin
			st_d.tx_empty = 1'b1;
			st_d.underrun = 1'b0;
			st_d.overrun = 1'b0;
			st_d.bus_err = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= '0;
			st_q.clk_ctl <= shu_pkg::CLOCK_CONTROL_RESET;
			st_q.ctl <= shu_pkg::CONTROL_RESET;
			st_q.own_addr <= shu_pkg::OWN_ADDRESS_RESET;
			st_q.tx_empty <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// interrupt requests, combinational so they follow flags each cycle
	// ************************************************************
	assign req_bus = st_q.bus_err && st_q.ctl[shu_pkg::BIT_BUS_ERR_IE];
	assign req_ovr = st_q.overrun && st_q.ctl[shu_pkg::BIT_RX_IE0];
	assign req_und = st_q.underrun && st_q.ctl[shu_pkg::BIT_TX_IE];
	assign req_full = fifo_full && st_q.ctl[shu_pkg::BIT_RX_IE1];
	assign req_tx = st_q.tx_empty && st_q.ctl[shu_pkg::BIT_TX_IE];
	assign req_ne = fifo_ne && st_q.ctl[shu_pkg::BIT_RX_IE0]
		&& !st_q.ctl[shu_pkg::BIT_RX_IE1];

	always_comb begin
		irq_vector_out = shu_pkg::VEC_TX_DATA;
		if (req_bus)
			irq_vector_out = shu_pkg::VEC_BUS_ERR;
		else if (req_ovr)
			irq_vector_out = shu_pkg::VEC_RX_OVERRUN;
		else if (req_und)
			irq_vector_out = shu_pkg::VEC_TX_UNDERRUN;
		else if (req_full)
			irq_vector_out = shu_pkg::VEC_RX_FULL;
		else if (req_tx)
			irq_vector_out = shu_pkg::VEC_TX_DATA;
		else if (req_ne)
			irq_vector_out = shu_pkg::VEC_RX_NOT_EMPTY;
	end

	assign irq_out = req_bus | req_ovr | req_und | req_full | req_tx | req_ne;
	assign rdata_out = st_q.rdata;
	assign tx_word_out = st_q.tx_hold;
	assign tx_word_valid_out = !st_q.tx_empty;
	assign clock_control_out = st_q.clk_ctl;
	assign own_address_out = st_q.own_addr;
	assign unit_enable_out = st_q.ctl[shu_pkg::BIT_ENABLE];
endmodule : shu_regmap

// *** tb/shu_regmap_monitor.sv ***
// checker for the serial host unit register map and interrupt vectoring
module shu_regmap_monitor (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// processor side
	input wire shu_pkg::shu_bus_s bus_in,
	input wire logic [23:0] rdata_out,
	// shift logic side
	input wire shu_pkg::shu_link_s link_in,
	input wire logic [23:0] tx_word_out,
	input wire logic tx_word_valid_out,
	input wire logic [23:0] clock_control_out,
	input wire logic [23:0] own_address_out,
	input wire logic unit_enable_out,
	// interrupt side
	input wire logic irq_out,
	input wire logic [15:0] irq_vector_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_tx_write;
		bus_in.wr && bus_in.addr == shu_pkg::ADDR_DATA && !link_in.tx_taken
			&& unit_enable_out;
	endsequence
	sequence s_rd(logic [15:0] a);
		bus_in.rd && !bus_in.wr && bus_in.addr == a;
	endsequence
	a_vec_not_reserved: assert property (irq_vector_out != 16'h0026)
		else $error("reserved vector shown");
	a_tx_write_load: assert property (s_tx_write |=> tx_word_valid_out &&
		tx_word_out == $past(bus_in.wdata)) else $error("holding not loaded");
	a_taken_sets_empty: assert property (link_in.tx_taken |=>
		!tx_word_valid_out) else $error("empty flag not set");
	a_tx_irq_empty: assert property (irq_out &&
		irq_vector_out == shu_pkg::VEC_TX_DATA |-> !tx_word_valid_out)
		else $error("tx request while full");
	a_bus_err_hold: assert property (irq_out && irq_vector_out ==
		shu_pkg::VEC_BUS_ERR && !bus_in.wr |=> irq_out &&
		irq_vector_out == shu_pkg::VEC_BUS_ERR) else $error("bus error lost");
	a_rd_unmapped: assert property (bus_in.rd &&
		bus_in.addr[15:2] != 14'h3ffc |=> rdata_out == 24'h000000)
		else $error("unmapped read not zero");
	a_rd_clock: assert property (s_rd(shu_pkg::ADDR_CLOCK_CONTROL) |=>
		rdata_out == $past(clock_control_out)) else $error("clock read bad");
	a_rd_own_addr: assert property (s_rd(shu_pkg::ADDR_OWN_ADDRESS) |=>
		rdata_out == $past(own_address_out) &&
		(rdata_out & 24'h0bffff) == 24'h000000) else $error("own read bad");
	a_rd_status_rsv: assert property (s_rd(shu_pkg::ADDR_CONTROL_STATUS)
		|=> (rdata_out & 24'h050000) == 24'h000000)
		else $error("status reserved bits set");
endmodule : shu_regmap_monitor

bind shu_regmap shu_regmap_monitor mon (.core_clk_in(core_clk_in),
	.reset_n_in(reset_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
	.link_in(link_in), .tx_word_out(tx_word_out),
	.tx_word_valid_out(tx_word_valid_out),
	.clock_control_out(clock_control_out),
	.own_address_out(own_address_out), .unit_enable_out(unit_enable_out),
	.irq_out(irq_out), .irq_vector_out(irq_vector_out));

// *** tb/shu_link_model.sv ***
// shift logic model: pushes words on command, takes holding word slowly
module shu_link_model (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// commands
	input wire logic push_in,
	input wire logic [23:0] word_in,
	input wire logic underrun_in,
	input wire logic bus_error_in,
	input wire logic tx_valid_in,
	// events to the unit
	output shu_pkg::shu_link_s link_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_q;
	logic take_q;
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_q <= 2'h0;
			take_q <= 1'b0;
		end else begin
			take_q <= tx_valid_in && wait_q == 2'h3 && !take_q;
			wait_q <= (tx_valid_in && !take_q) ? wait_q + 2'h1 : 2'h0;
		end
	end
	// word line shows garbage outside a push
	assign link_out = '{push_in, push_in ? word_in : ~word_in, take_q,
		underrun_in, bus_error_in};
endmodule : shu_link_model

// *** tb/shu_regmap_bench.sv ***
// testbench for the serial host unit register map
module shu_regmap_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// harness
	// ************************************************************
	logic core_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	shu_pkg::shu_bus_s bus_in = '0;
	shu_pkg::shu_link_s link;
	logic push = 1'b0, und = 1'b0, berr = 1'b0, tx_v, en, irq;
	logic [23:0] word = 24'h0, rdata, tx_word, ccr, own;
	logic [15:0] vec;
	int num_errors = 0;
	int samples_checked = 0;
	always #12.5 core_clk_in = ~core_clk_in;
	shu_regmap dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.bus_in(bus_in), .rdata_out(rdata), .link_in(link),
		.tx_word_out(tx_word), .tx_word_valid_out(tx_v),
		.clock_control_out(ccr), .own_address_out(own),
		.unit_enable_out(en), .irq_out(irq), .irq_vector_out(vec));
	shu_link_model far (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.push_in(push), .word_in(word), .underrun_in(und),
		.bus_error_in(berr), .tx_valid_in(tx_v), .link_out(link));
	task chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [23:0] d);
		@(posedge core_clk_in);
		bus_in <= '{1'b0, 1'b1, a, d};
		@(posedge core_clk_in);
		bus_in.wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [15:0] a, input logic [23:0] e);
		@(posedge core_clk_in);
		bus_in <= '{1'b1, 1'b0, a, 24'h0};
		@(posedge core_clk_in);
		bus_in.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd
	task ev(input logic p, input logic u, input logic b, input logic [23:0] w);
		@(posedge core_clk_in);
		{push, und, berr, word} <= {p, u, b, w};
		@(posedge core_clk_in);
		{push, und, berr} <= 3'h0;
		#1;
	endtask : ev
	task wrap_up;
		$display("TB: errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		#100us;
		num_errors++;
		wrap_up();
	end
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		int k;
		repeat (8) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		rd(16'hfff0, 24'h000001);
		rd(16'hfff1, 24'h008000);
		rd(16'hfff2, 24'hb00000);
		rd(16'hfff4, 24'h000000);
		chk({23'h0, irq}, 24'h0);
		chk({23'h0, en}, 24'h0);
		wr(16'hfff0, 24'hffffff);
		rd(16'hfff0, 24'h0031ff);
		chk(ccr, 24'h0031ff);
		wr(16'hfff2, 24'hffffff);
		rd(16'hfff2, 24'hf40000);
		chk(own, 24'hf40000);
		$display("TB: register test done");
		wr(16'hfff1, 24'h003c01);
		chk({23'h0, en}, 24'h1);
		chk({8'h0, vec}, 24'h000020);
		for (k = 0; k < 10; k++) begin
			ev(1'b1, 1'b0, 1'b0, {20'ha5000, k[3:0]});
		end
		chk({8'h0, vec}, 24'h000028);
		rd(16'hfff1, 24'h0abc01);
		ev(1'b1, 1'b0, 1'b0, 24'h000777);
		chk({8'h0, vec}, 24'h00002a);
		ev(1'b0, 1'b1, 1'b0, 24'h0);
		chk({8'h0, vec}, 24'h00002a);
		ev(1'b0, 1'b0, 1'b1, 24'h0);
		chk({8'h0, vec}, 24'h00002c);
		wr(16'hfff1, 24'h003c01);
		chk({8'h0, vec}, 24'h000028);
		for (k = 0; k < 10; k++) begin
			rd(16'hfff3, {20'ha5000, k[3:0]});
		end
		rd(16'hfff3, 24'h000000);
		chk({8'h0, vec}, 24'h000020);
		ev(1'b0, 1'b1, 1'b0, 24'h0);
		chk({8'h0, vec}, 24'h000022);
		$display("TB: priority test done");
		wr(16'hfff1, 24'h003c01);
		wr(16'hfff3, 24'h5a5a5a);
		chk(tx_word, 24'h5a5a5a);
		chk({23'h0, irq}, 24'h0);
		for (k = 0; k < 20 && tx_v !== 1'b0; k++) @(posedge core_clk_in);
		#1;
		if (tx_v !== 1'b0) begin
			num_errors++;
			$display("BAD %0t holding word never taken", $time);
			wrap_up();
		end
		chk({8'h0, vec}, 24'h000020);
		wr(16'hfff1, 24'h001001);
		ev(1'b1, 1'b0, 1'b0, 24'h123456);
		chk({8'h0, vec}, 24'h000024);
		rd(16'hfff3, 24'h123456);
		chk({23'h0, irq}, 24'h0);
		$display("TB: transmit and not empty test done");
		wrap_up();
	end
endmodule : shu_regmap_bench
